//--- include/fht_pkg.sv
// Constants, types and decode functions for the host transfer and command block
`default_nettype none

package fht_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 20;                         // core_clk period
  localparam int SVC_TIME_NS   = 14000;                      // Byte service time
  localparam int SVC_CYCLES    = SVC_TIME_NS / CLK_PERIOD_NS; // Rounded down

  ////////////////////////////////////////////////////////////////////////////
  // Opcode low five bits
  localparam logic [4:0] OPC_READ     = 5'h06;
  localparam logic [4:0] OPC_READ_DEL = 5'h0C;
  localparam logic [4:0] OPC_WRITE    = 5'h05;
  localparam logic [4:0] OPC_READ_ID  = 5'h0A;
  localparam logic [4:0] OPC_FORMAT   = 5'h0D;

  // Command and result lengths in bytes
  localparam logic [3:0] LEN_RW      = 4'h9;
  localparam logic [3:0] LEN_FMT     = 4'h6;
  localparam logic [3:0] LEN_RID     = 4'h2;
  localparam logic [3:0] LEN_INVALID = 4'h1;
  localparam logic [2:0] RES_LEN     = 3'h7;
  localparam logic [2:0] RES_LEN_INV = 3'h1;

  // Opcode byte option bits
  localparam int OPT_MT = 7;
  localparam int OPT_DD = 6;
  localparam int OPT_SK = 5;
  // Unit byte fields
  localparam int UNIT_IPS  = 7;
  localparam int UNIT_HEAD = 2;
  localparam int UNIT_HI   = 1;
  localparam int UNIT_LO   = 0;

  // Main status bit positions
  localparam int MSR_RQM  = 7;
  localparam int MSR_DIO  = 6;
  localparam int MSR_NDMA = 5;
  localparam int MSR_BUSY = 4;

  // Status values
  localparam int         ST1_OVERRUN = 4;
  localparam logic [7:0] ST0_INVALID = 8'h80;
  localparam logic [7:0] BYTE_RST    = 8'h00;
  localparam logic [9:0] SVC_LIMIT   = 10'(SVC_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {
    CMD_READ, CMD_READ_DEL, CMD_WRITE, CMD_READ_ID, CMD_FORMAT, CMD_INVALID
  } fht_cmd_type;

  typedef enum logic [1:0] {PH_CMD, PH_EXEC, PH_RES} fht_phase_type;

  ////////////////////////////////////////////////////////////////////////////
  // Decode functions
  function automatic fht_cmd_type cmd_decode(input logic [4:0] opc);
    unique case (opc)
      OPC_READ:     cmd_decode = CMD_READ;
      OPC_READ_DEL: cmd_decode = CMD_READ_DEL;
      OPC_WRITE:    cmd_decode = CMD_WRITE;
      OPC_READ_ID:  cmd_decode = CMD_READ_ID;
      OPC_FORMAT:   cmd_decode = CMD_FORMAT;
      default:      cmd_decode = CMD_INVALID;
    endcase
  endfunction

  function automatic logic [3:0] cmd_length(input fht_cmd_type kind);
    unique case (kind)
      CMD_READ, CMD_READ_DEL, CMD_WRITE: cmd_length = LEN_RW;
      CMD_FORMAT:                        cmd_length = LEN_FMT;
      CMD_READ_ID:                       cmd_length = LEN_RID;
      default:                           cmd_length = LEN_INVALID;
    endcase
  endfunction

endpackage

`default_nettype wire

//--- verilog/fht_buf2.sv
// Two-entry buffer with valid and ready on both sides
`default_nettype none

module fht_buf2 #(
  parameter int WIDTH = 8                  // Word width
) (
  input  wire logic             core_clk,  // Core clock
  input  wire logic             srst,      // Synchronous reset
  input  wire logic             flush,     // Drop all entries
  input  wire logic             in_valid,  // Word offered
  output logic                  in_ready,  // Room for a word
  input  wire logic [WIDTH-1:0] in_data,   // Word in
  output logic                  out_valid, // Word held
  input  wire logic             out_ready, // Word taken
  output logic      [WIDTH-1:0] out_data   // Oldest word
);

  logic [WIDTH-1:0] mem [0:1];
  logic             wr_ptr;
  logic             rd_ptr;
  logic [1:0]       count;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  // Honest full and empty flags
  assign in_ready  = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data  = mem[rd_ptr];

  // Pointers and occupancy
  always_ff @(posedge core_clk) begin
    if (srst || flush) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      wr_ptr <= wr_ptr ^ push;
      rd_ptr <= rd_ptr ^ pop;
      count  <= count + {1'b0, push} - {1'b0, pop};
    end
  end

  // Storage
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

endmodule

`default_nettype wire

//--- verilog/fht_core.sv
// Host transfer, command and result handling of the disk controller
`default_nettype none
// Function
// - With DMA on, request DMA in execution whenever a byte is ready.
// - DMA works only when mode option and control DMA enable both set.
// - DMA request drops on the falling acknowledge.
// - In DMA mode, interrupt after last byte marks result phase start.
// - Terminal count ends operation, accepted only while acknowledge is low.
// - Without DMA, interrupt in execution whenever a byte is ready.
// - Per-byte interrupt shows status bits 5 and 7 set.
// - Per-byte interrupt drops once the byte is transferred; here it stays up while the buffer holds a byte (read) or has room (write).
// - Missed service time sets overrun and ends command at sector end.
// - Result interrupt without DMA shows bits 7, 6 set, 5 clear.
// - Reading the first result byte clears the result interrupt.
// - Without DMA, status bit 7 follows the interrupt output during execution.
// - Read, read deleted, write take nine command bytes.
// - Format takes six command bytes.

module fht_core
  import fht_pkg::*;
(
  input  wire logic              core_clk,           // Core clock
  input  wire logic              srst,               // Synchronous reset
  // Host side
  input  wire logic              cs_n,               // Chip select
  input  wire logic              rd_stb,             // Read strobe pulse
  input  wire logic              wr_stb,             // Write strobe pulse
  input  wire logic              reg_sel,            // 0 status, 1 data
  input  wire logic [7:0]        wr_data,            // Write byte
  output logic      [7:0]        rd_data,            // Read byte
  output logic                   irq,                // Interrupt
  // DMA side
  output logic                   dma_req,            // DMA request
  input  wire logic              dma_ack_n,          // DMA acknowledge
  input  wire logic              terminal_count,     // End of transfer
  // Configuration
  input  wire logic              dma_mode_opt,       // Timing-setup DMA option
  input  wire logic              dcr_dma_en,         // Drive control DMA enable
  input  wire logic [3:0]        seek_busy,          // Drives seeking
  // Media engine side
  output logic                   cmd_start,          // New command pulse
  output fht_pkg::fht_cmd_type   cmd_kind,           // Decoded command
  output logic                   multi_track_opt,    // Option bit
  output logic                   double_density_opt, // Option bit
  output logic                   skip_deleted_opt,   // Option bit
  output logic                   implied_seek_opt,   // Option bit
  output logic                   head_sel,           // Head select
  output logic                   unit_sel_hi,        // Drive select high
  output logic                   unit_sel_lo,        // Drive select low
  output logic      [7:0]        prm_track,          // Track
  output logic      [7:0]        prm_head,           // Head number
  output logic      [7:0]        prm_sector,         // Sector
  output logic      [7:0]        prm_size,           // Size code
  output logic      [7:0]        prm_last,           // Last sector or count
  output logic      [7:0]        prm_gap,            // Gap length
  output logic      [7:0]        prm_len,            // Data length or fill
  output logic                   term_req,           // Terminal count pulse
  output logic                   overrun,            // Service time missed
  input  wire logic              disk_rx_valid,      // Byte from media
  output logic                   disk_rx_ready,      // Media byte taken
  input  wire logic [7:0]        disk_rx_data,       // Media byte
  output logic                   disk_tx_valid,      // Byte to media
  input  wire logic              disk_tx_ready,      // Media takes byte
  output logic      [7:0]        disk_tx_data,       // Byte to media
  input  wire logic              exec_done,          // Execution over pulse
  input  wire logic [7:0]        res_st0,            // Status 0
  input  wire logic [7:0]        res_st1,            // Status 1
  input  wire logic [7:0]        res_st2,            // Status 2
  input  wire logic [7:0]        res_track,          // Track
  input  wire logic [7:0]        res_head,           // Head
  input  wire logic [7:0]        res_sector,         // Sector
  input  wire logic [7:0]        res_size            // Size code
);
  import fht_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State
  fht_phase_type phase;
  fht_phase_type next_phase;
  logic [7:0]    cmd_mem [0:8];
  logic [7:0]    res_mem [0:6];
  logic [3:0]    cmd_idx;
  logic [2:0]    res_idx;
  logic [2:0]    res_len;
  logic          res_irq;
  logic [9:0]    svc_cnt;
  wire  [7:0]    msr;

  ////////////////////////////////////////////////////////////////////////////
  // Access decode
  wire host_acc = !cs_n;
  wire dma_acc  = !dma_ack_n;
  wire msr_rd   = host_acc & rd_stb & !reg_sel;
  wire data_rd  = (host_acc & reg_sel | dma_acc) & rd_stb;
  wire data_wr  = (host_acc & reg_sel | dma_acc) & wr_stb;
  wire in_cmd   = (phase == PH_CMD);
  wire in_exec  = (phase == PH_EXEC);
  wire in_res   = (phase == PH_RES);
  wire dma_on   = dma_mode_opt & dcr_dma_en;

  // Command byte collection; length from the opcode on byte 0
  wire         cmd_wr    = in_cmd & data_wr;
  wire         first_b   = (cmd_idx == 4'h0);
  fht_cmd_type cur_kind;
  assign cur_kind = first_b ? cmd_decode(wr_data[4:0]) : cmd_kind;
  wire         last_cmd  = cmd_wr & (cmd_idx + 4'h1 == cmd_length(cur_kind));
  wire         bad_cmd   = last_cmd & (cur_kind == CMD_INVALID);

  // Transfer direction during execution
  wire to_host   = (cmd_kind == CMD_READ) | (cmd_kind == CMD_READ_DEL);
  wire from_host = (cmd_kind == CMD_WRITE) | (cmd_kind == CMD_FORMAT);

  ////////////////////////////////////////////////////////////////////////////
  // Execution data path through the two-entry buffer
  logic       buf_in_ready;
  logic       buf_out_valid;
  logic [7:0] buf_out_data;
  wire        buf_in_valid  = in_exec & (to_host ? disk_rx_valid : from_host & data_wr);
  wire [7:0]  buf_in_data   = to_host ? disk_rx_data : wr_data;
  wire        buf_out_ready = in_exec & (to_host ? data_rd : from_host & disk_tx_ready);
  wire        leave_exec    = in_exec & exec_done;

  fht_buf2 #(
    .WIDTH(8)
  ) u_buf (
    .core_clk  (core_clk),
    .srst      (srst),
    .flush     (leave_exec),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (buf_in_data),
    .out_valid (buf_out_valid),
    .out_ready (buf_out_ready),
    .out_data  (buf_out_data)
  );

  assign disk_rx_ready = in_exec & to_host & buf_in_ready;
  assign disk_tx_valid = in_exec & from_host & buf_out_valid;
  assign disk_tx_data  = buf_out_data;

  // A byte waits for the host, and whether the host moved it now
  wire byte_ready = in_exec & (to_host & buf_out_valid | from_host & buf_in_ready);
  wire byte_moved = in_exec & (to_host ? data_rd & buf_out_valid : from_host & data_wr & buf_in_ready);

  ////////////////////////////////////////////////////////////////////////////
  // Request outputs and main status
  assign dma_req = dma_on & byte_ready & dma_ack_n;
  assign irq     = res_irq | (!dma_on & byte_ready);
  assign msr[MSR_RQM]  = in_cmd | in_res | (!dma_on & byte_ready);
  assign msr[MSR_DIO]  = in_res | (in_exec & to_host);
  assign msr[MSR_NDMA] = in_exec & !dma_on;
  assign msr[MSR_BUSY] = !in_cmd | !first_b;
  assign msr[3:0]      = seek_busy;

  ////////////////////////////////////////////////////////////////////////////
  // Phase sequencing
  wire res_rd   = in_res & data_rd;
  wire last_res = res_rd & (res_idx + 3'h1 == res_len);

  always_comb begin
    next_phase = phase;
    unique case (phase)
      PH_CMD:  if (last_cmd) next_phase = bad_cmd ? PH_RES : PH_EXEC;
      PH_EXEC: if (exec_done) next_phase = PH_RES;
      PH_RES:  if (last_res) next_phase = PH_CMD;
    endcase
  end

  // Phase register
  always_ff @(posedge core_clk) begin
    if (srst) phase <= PH_CMD;
    else      phase <= next_phase;
  end

  // Command byte index and start pulse
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cmd_idx   <= 4'h0;
      cmd_start <= 1'b0;
    end else begin
      cmd_idx   <= !cmd_wr ? cmd_idx : (last_cmd ? 4'h0 : cmd_idx + 4'h1);
      cmd_start <= last_cmd & !bad_cmd;
    end
  end

  // Command bytes and decoded kind
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cmd_kind <= CMD_INVALID;
      for (int i = 0; i < 9; i++) cmd_mem[i] <= BYTE_RST;
    end else if (cmd_wr) begin
      cmd_mem[cmd_idx] <= wr_data;
      if (first_b) cmd_kind <= cur_kind;
    end
  end

  // Parameter fields; format has its own byte layout
  wire fmt = (cmd_kind == CMD_FORMAT);
  assign multi_track_opt    = cmd_mem[0][OPT_MT] & !fmt & (cmd_kind != CMD_READ_ID);
  assign double_density_opt = cmd_mem[0][OPT_DD];
  assign skip_deleted_opt   = cmd_mem[0][OPT_SK] & !fmt & (cmd_kind != CMD_READ_ID) & (cmd_kind != CMD_WRITE);
  assign implied_seek_opt   = cmd_mem[1][UNIT_IPS] & !fmt & (cmd_kind != CMD_READ_ID);
  assign head_sel           = cmd_mem[1][UNIT_HEAD];
  assign unit_sel_hi        = cmd_mem[1][UNIT_HI];
  assign unit_sel_lo        = cmd_mem[1][UNIT_LO];
  assign prm_track  = fmt ? BYTE_RST : cmd_mem[2];
  assign prm_head   = fmt ? BYTE_RST : cmd_mem[3];
  assign prm_sector = fmt ? BYTE_RST : cmd_mem[4];
  assign prm_size   = fmt ? cmd_mem[2] : cmd_mem[5];
  assign prm_last   = fmt ? cmd_mem[3] : cmd_mem[6];
  assign prm_gap    = fmt ? cmd_mem[4] : cmd_mem[7];
  assign prm_len    = fmt ? cmd_mem[5] : cmd_mem[8];

  ////////////////////////////////////////////////////////////////////////////
  // Service timer and overrun
  wire svc_expire = byte_ready & !byte_moved & (svc_cnt == SVC_LIMIT);

  always_ff @(posedge core_clk) begin
    if (srst)                      svc_cnt <= 10'h000;
    else if (byte_ready & !byte_moved) svc_cnt <= (svc_cnt == SVC_LIMIT) ? svc_cnt : svc_cnt + 10'h001;
    else                           svc_cnt <= 10'h000;
  end

  // Overrun stays until the next command starts
  always_ff @(posedge core_clk) begin
    if (srst)            overrun <= 1'b0;
    else if (svc_expire) overrun <= 1'b1;
    else if (cmd_start)  overrun <= 1'b0;
  end

  // Terminal count only counts while acknowledge is low
  always_ff @(posedge core_clk) begin
    if (srst) term_req <= 1'b0;
    else      term_req <= in_exec & terminal_count & dma_acc;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result bytes
  always_ff @(posedge core_clk) begin
    if (srst) begin
      for (int i = 0; i < 7; i++) res_mem[i] <= BYTE_RST;
      res_len <= RES_LEN;
    end else if (leave_exec) begin
      res_mem[0] <= res_st0;
      res_mem[1] <= res_st1 | (8'(overrun | svc_expire) << ST1_OVERRUN);
      res_mem[2] <= res_st2;
      res_mem[3] <= res_track;
      res_mem[4] <= res_head;
      res_mem[5] <= res_sector;
      res_mem[6] <= res_size;
      res_len    <= RES_LEN;
    end else if (bad_cmd) begin
      res_mem[0] <= ST0_INVALID;
      res_len    <= RES_LEN_INV;
    end
  end

  // Result index
  always_ff @(posedge core_clk) begin
    if (srst)        res_idx <= 3'h0;
    else if (res_rd) res_idx <= last_res ? 3'h0 : res_idx + 3'h1;
  end

  // Result interrupt, set on entering the result phase from execution
  always_ff @(posedge core_clk) begin
    if (srst)            res_irq <= 1'b0;
    else if (leave_exec) res_irq <= 1'b1;
    else if (res_rd)     res_irq <= 1'b0;
  end

  // Read data register
  always_ff @(posedge core_clk) begin
    if (srst)                  rd_data <= BYTE_RST;
    else if (msr_rd)           rd_data <= msr;
    else if (res_rd)           rd_data <= res_mem[res_idx];
    else if (in_exec & data_rd) rd_data <= buf_out_data;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence s_last_exec;
    in_exec ##0 exec_done;
  endsequence

  sequence s_first_res_rd;
    in_res && data_rd && res_idx == 3'h0;
  endsequence

  dma_req_gate_a: assert property (dma_req |-> dma_mode_opt && dcr_dma_en)
    else $error("DMA request without both enables");
  dma_req_need_a: assert property (in_exec && dma_on && byte_ready && dma_ack_n |-> dma_req)
    else $error("ready byte without DMA request");
  dma_ack_drop_a: assert property ($fell(dma_ack_n) |-> !dma_req)
    else $error("DMA request held past acknowledge");
  tc_gate_a: assert property (term_req |-> $past(terminal_count) && !$past(dma_ack_n) && $past(in_exec))
    else $error("terminal count taken without acknowledge");
  tc_refused_a: assert property (dma_ack_n |=> !term_req)
    else $error("terminal count taken with acknowledge high");
  byte_irq_a: assert property (!dma_on && byte_ready |-> irq && msr[MSR_RQM] && msr[MSR_NDMA])
    else $error("per-byte interrupt status wrong");
  res_irq_set_a: assert property (s_last_exec |=> irq && in_res && msr[7:5] == 3'b110)
    else $error("result interrupt or status missing");
  res_irq_clr_a: assert property (s_first_res_rd |=> !res_irq)
    else $error("result interrupt not cleared");
  poll_follow_a: assert property (in_exec && !dma_on |-> msr[MSR_RQM] == irq)
    else $error("status bit 7 differs from interrupt");
  overrun_set_a: assert property (byte_ready && !byte_moved && svc_cnt == SVC_LIMIT |=> overrun)
    else $error("overrun not flagged");
  cmd_len_a: assert property (cmd_wr && !first_b && cmd_kind == CMD_FORMAT
                              |-> last_cmd == (cmd_idx == LEN_FMT - 4'h1))
    else $error("format length check");
  start_len_a: assert property (cmd_start |-> $past(cmd_idx) == cmd_length(cmd_kind) - 4'h1)
    else $error("command started at wrong byte count");

endmodule

`default_nettype wire

//--- sim/fht_dma_model.sv
// DMA controller model that answers the controller's transfer requests
`default_nettype none
module fht_dma_model (
  input  wire logic       core_clk,  // Core clock
  input  wire logic       srst,      // Synchronous reset
  input  wire logic       dma_req,   // Request from controller
  input  wire logic       last_byte, // Raise terminal count with this byte
  input  wire logic [3:0] stall,     // Cycles before answering
  input  wire logic [7:0] rd_data,   // Byte on the data bus
  output logic            dma_ack_n, // Acknowledge, active low
  output logic            dma_rd,    // Read strobe
  output logic            dma_tc,    // Terminal count
  output logic      [7:0] got,       // Byte moved
  output logic            got_valid  // Byte moved pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_cnt;
  logic       pend;
  ////////////////////////////////////////////////////////////////////////////
  // Acknowledge plus strobe for one cycle, then take the byte a cycle later
  always_ff @(posedge core_clk) begin
    got_valid <= pend;
    got       <= rd_data;
    pend      <= !srst && !dma_ack_n;
    if (srst || !dma_ack_n) begin
      {dma_ack_n, dma_rd, dma_tc, wait_cnt} <= 7'h40;
    end else if (dma_req && wait_cnt == stall) begin
      {dma_ack_n, dma_rd, dma_tc} <= {2'h1, last_byte};
    end else if (dma_req) begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

//--- sim/test_fht_core.sv
// Self-checking bench for the host transfer and command block
`default_nettype none
module test_fht_core;
  timeunit 1ns;
  timeprecision 1ps;
  import fht_pkg::*;
  logic core_clk, srst, cs_n, h_rd, wr_stb, reg_sel, irq, dma_req, dma_ack_n, tc_bad, dma_mode_opt, dcr_dma_en;
  logic cmd_start, term_req, overrun, exec_done, last_byte, multi_track_opt, double_density_opt;
  logic skip_deleted_opt, implied_seek_opt, head_sel, unit_sel_hi, unit_sel_lo, disk_rx_valid;
  logic disk_rx_ready, disk_tx_valid, disk_tx_ready, m_rd, m_tc, got_valid, rd_stb, terminal_count;
  logic [3:0] seek_busy, stall;
  logic [7:0] wr_data, rd_data, disk_rx_data, disk_tx_data, got, d;
  logic [7:0] prm_track, prm_head, prm_sector, prm_size, prm_last, prm_gap, prm_len;
  logic [7:0] res_st0, res_st1, res_st2, res_track, res_head, res_sector, res_size;
  logic [7:0] opc [5] = '{8'h4C, 8'hC5, 8'h4D, 8'h4A, 8'h1F};
  int lens [5] = '{9, 9, 6, 2, 1};
  fht_cmd_type cmd_kind;
  fht_cmd_type kinds [5] = '{CMD_READ_DEL, CMD_WRITE, CMD_FORMAT, CMD_READ_ID, CMD_INVALID};
  int failures = 0, comparisons = 0, starts = 0, tcs = 0, cycles = 0;
  // Host and DMA strobes share the data path
  assign rd_stb = h_rd | m_rd;
  assign terminal_count = tc_bad | m_tc;
  fht_core i_dut (.*);
  fht_dma_model i_dma (.core_clk(core_clk), .srst(srst), .dma_req(dma_req), .last_byte(last_byte), .stall(stall),
    .rd_data(rd_data), .dma_ack_n(dma_ack_n), .dma_rd(m_rd), .dma_tc(m_tc), .got(got), .got_valid(got_valid));
  ////////////////////////////////////////////////////////////////////////////
  // Clock, pulse counters and hang limit
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cmd_start) starts++;
    if (term_req) tcs++;
    if (!dma_ack_n) chk(64'(dma_req), 64'h0);
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end
  end
  // Compare and count
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Host read: one-cycle strobe, byte ready after the taking edge
  task automatic hrd(input logic sel, output logic [7:0] v);
    cs_n    <= 1'h0;
    reg_sel <= sel;
    h_rd    <= 1'h1;
    @(posedge core_clk);
    h_rd <= 1'h0;
    @(posedge core_clk);
    v = rd_data;
  endtask
  // Poll main status until request set and direction matches
  task automatic poll(input logic dir);
    do hrd(1'h0, d); while (d[7:6] !== {1'h1, dir});
  endtask
  // Command phase: n bytes from the top of b
  task automatic cmd(input logic [71:0] b, input int n, input int exp);
    int s;
    s = starts;
    for (int i = 0; i < n; i++) begin
      poll(1'h0);
      reg_sel <= 1'h1;
      wr_data <= b[71-8*i -: 8];
      wr_stb  <= 1'h1;
      @(posedge core_clk);
      wr_stb <= 1'h0;
    end
    repeat (2) @(posedge core_clk);
    chk(64'(starts - s), 64'(exp));
  endtask
  // Media byte offered until the buffer takes it, then the line is scrambled
  task automatic mbyte(input logic [7:0] v);
    disk_rx_valid <= 1'h1;
    disk_rx_data  <= v;
    do @(negedge core_clk); while (!disk_rx_ready);
    @(posedge core_clk);
    disk_rx_valid <= 1'h0;
    disk_rx_data  <= ~v;
    @(posedge core_clk);
  endtask
  // Wait for the DMA model to move a byte
  task automatic wait_got(input logic [7:0] v);
    do @(negedge core_clk); while (!got_valid);
    chk(64'(got), 64'(v));
    @(posedge core_clk);
  endtask
  // End execution and read the seven result bytes
  task automatic finish(input logic [55:0] rs, input logic [7:0] st1_or);
    {res_st0, res_st1, res_st2, res_track, res_head, res_sector, res_size} <= rs;
    exec_done <= 1'h1;
    @(posedge core_clk);
    exec_done <= 1'h0;
    @(negedge core_clk);
    chk(64'(irq), 64'h1);
    @(posedge core_clk);
    hrd(1'h0, d);
    chk(64'(d), 64'hD0);
    for (int i = 0; i < 7; i++) begin
      poll(1'h1);
      hrd(1'h1, d);
      chk(64'(d), 64'(rs[55-8*i -: 8] | (i == 1 ? st1_or : 8'h00)));
      if (i == 0) chk(64'(irq), 64'h0);
    end
    hrd(1'h0, d);
    chk(64'(d), 64'h80);
  endtask
  // Counts and verdict
  task automatic complete_run();
    $display("Comparisons %0d, failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    {core_clk, srst, cs_n, h_rd, wr_stb, reg_sel, tc_bad, dma_mode_opt, dcr_dma_en} = 9'h0C0;
    {disk_rx_valid, disk_tx_ready, exec_done, last_byte, seek_busy, stall} = 12'h000;
    {wr_data, disk_rx_data} = 16'h0000;
    {res_st0, res_st1, res_st2, res_track, res_head, res_sector, res_size} = 56'h0;
    repeat (8) @(posedge core_clk);
    srst <= 1'h0;
    @(posedge core_clk);
    hrd(1'h0, d);
    chk(64'({d, irq, dma_req}), 64'h200);
    seek_busy <= 4'hA;
    hrd(1'h0, d);
    chk(64'(d), 64'h8A);
    seek_busy <= 4'h0;
    $display("Test reset done");
    // Read with all options, buffer filled until refused, drained by interrupt
    cmd(72'hE6_85_01_02_03_04_05_06_07, 9, 1);
    chk(64'({cmd_kind, multi_track_opt, double_density_opt, skip_deleted_opt, implied_seek_opt,
      head_sel, unit_sel_hi, unit_sel_lo}), 64'({CMD_READ, 7'h7D}));
    chk({8'h00, prm_track, prm_head, prm_sector, prm_size, prm_last, prm_gap, prm_len}, 64'h01020304050607);
    mbyte(8'h3C);
    mbyte(8'hC3);
    @(negedge core_clk);
    chk(64'({disk_rx_ready, irq, dma_req}), 64'h2);
    @(posedge core_clk);
    hrd(1'h0, d);
    chk(64'(d & 8'hA0), 64'hA0);
    hrd(1'h1, d);
    chk(64'(d), 64'h3C);
    hrd(1'h1, d);
    chk(64'(d), 64'hC3);
    hrd(1'h0, d);
    chk(64'({d[7], irq}), 64'h0);
    finish(56'h01_02_03_04_05_06_07, 8'h00);
    $display("Test interrupt read done");
    // Byte left unserviced past the limit
    cmd(72'h46_01_10_00_01_02_01_1B_FF, 9, 1);
    mbyte(8'h5A);
    repeat (720) @(posedge core_clk);
    chk(64'(overrun), 64'h1);
    finish(56'h40_00_00_10_00_01_02, 8'h10);
    $display("Test overrun done");
    // DMA option alone, then with enable; chip select held high for DMA
    dma_mode_opt <= 1'h1;
    cmd(72'h06_00_01_00_01_02_01_1B_FF, 9, 1);
    chk(64'(overrun), 64'h0);
    mbyte(8'h11);
    @(negedge core_clk);
    chk(64'({irq, dma_req}), 64'h2);
    @(posedge core_clk);
    hrd(1'h1, d);
    chk(64'(d), 64'h11);
    {cs_n, dcr_dma_en, tc_bad, stall} <= 7'h7C;
    mbyte(8'h22);
    repeat (2) @(negedge core_clk);
    chk(64'({irq, dma_req}), 64'h1);
    @(posedge core_clk);
    tc_bad <= 1'h0;
    chk(64'(tcs), 64'h0);
    wait_got(8'h22);
    {last_byte, stall} <= 5'h10;
    mbyte(8'h33);
    wait_got(8'h33);
    chk(64'(tcs), 64'h1);
    finish(56'h00_00_00_01_00_02_02, 8'h00);
    {last_byte, dcr_dma_en, dma_mode_opt} <= 3'h0;
    $display("Test DMA done");
    // Remaining commands and an unknown opcode
    for (int i = 0; i < 5; i++) begin
      cmd({opc[i], 64'h86_11_22_33_44_55_66_77}, lens[i], int'(i < 4));
      chk(64'(cmd_kind), 64'(kinds[i]));
      if (i == 1) cmd({8'hA5, 64'h0}, 1, 0);
      if (i == 1) chk(64'({disk_tx_valid, disk_tx_data}), 64'h1A5);
      if (i == 2) chk(64'({prm_size, prm_last, prm_gap, prm_len}), 64'h11223344);
      if (i == 3) chk(64'({double_density_opt, implied_seek_opt, head_sel, unit_sel_hi, unit_sel_lo}), 64'h16);
      if (i < 4) finish(56'h00_00_00_05_01_03_02, 8'h00);
      else begin
        poll(1'h1);
        hrd(1'h1, d);
        chk(64'(d), 64'(ST0_INVALID));
      end
    end
    $display("Test command table done");
    complete_run();
  end
endmodule
`default_nettype wire
